// *** nv_store_pkg.sv ***
// Package: register map, field layout and timing constants of the byte store controller
package nv_store_pkg;

	// Register byte addresses (one aligned word each)
	localparam logic [7:0] addr_high_off   = 8'h00;
	localparam logic [7:0] addr_low_off    = 8'h04;
	localparam logic [7:0] data_byte_off   = 8'h08;
	localparam logic [7:0] unlock_port_off = 8'h0c;
	localparam logic [7:0] control_off     = 8'h10;
	localparam logic [7:0] priority_off    = 8'h14;
	localparam logic [7:0] flags_off       = 8'h18;
	localparam logic [7:0] enables_off     = 8'h1c;
	localparam logic [7:0] status_off      = 8'h20;

	// Control register bit positions
	localparam int ctl_read_bit   = 0;
	localparam int ctl_start_bit  = 1;
	localparam int ctl_unlock_bit = 2;
	localparam int ctl_abort_bit  = 3;
	localparam int ctl_free_bit   = 4;
	localparam int ctl_config_space_select_bit   = 6;
	localparam int ctl_pgd_bit    = 7;
	// Done flag, enable and priority bit position
	localparam int done_bit       = 4;

	// Unlock keys
	localparam logic [7:0] key_first  = 8'h55;
	localparam logic [7:0] key_second = 8'haa;

	// Address width and memory depth
	localparam int addr_width = 10;
	localparam int mem_depth  = 1024;

	// Reset values
	localparam logic [7:0] ctl_reset = 8'h00;
	localparam logic [7:0] byte_zero = 8'h00;

	// AXI responses
	localparam logic [1:0] resp_okay   = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

	// Self-timed write length and power-up timer, in ns and cycles at 8 ns
	localparam int clk_period_ns  = 8;
	localparam int write_time_ns  = 4000;
	localparam int write_cycles   = write_time_ns / clk_period_ns;
	localparam int powerup_ns     = 65536;
	localparam int powerup_cycles = (powerup_ns + clk_period_ns - 1) / clk_period_ns;

	// Unlock tracker steps
	typedef enum logic [1:0] {
		unlock_idle,
		unlock_got_first,
		unlock_armed
	} unlock_step_t;

	// Memory port
	typedef struct packed {
		logic                  wr;
		logic [addr_width-1:0] addr;
		logic [7:0]            wdata;
	} mem_req_t;

endpackage : nv_store_pkg

// *** nv_byte_array.sv ***
// Byte-wide storage array with registered read data
`timescale 1ns/1ps
module nv_byte_array
	import nv_store_pkg::*;
(
	input  wire logic       clk,
	input  wire mem_req_t   req,
	output logic [7:0]      rdata
);
	// Storage cells
	logic [7:0] cells [mem_depth];

	// Write on request, read data always registered
	always_ff @(posedge clk) begin
		if (req.wr) begin
			cells[req.addr] <= req.wdata;
		end
		rdata <= cells[req.addr];
	end
endmodule : nv_byte_array

// *** nv_byte_store_ctrl.sv ***
// Byte store controller: unlock sequence, self-timed write, flags, AXI4-Lite registers
`timescale 1ns/1ps
// Functional notes
// - Write starts only after 55, AA, start
// - No write without write-enable set
// - Hardware never clears write-enable
// - Address, data and control registers frozen while write runs
// - Start refused if enable set together
// - Completion clears start, sets done flag
// - Done flag cleared only by software
// - Self-write forces high-power mode
// - Code protect blocks external accesses
// - Internal accesses ignore code protect
// - Write-enable cleared at power-up
// - Writes blocked during power-up timer
// - Separate address high, low, data registers
// - Ten-bit address, two high bits used
// - Read bit loads data next cycle
// - Done flag is bit 4 of flags
// - Abort flag on bad attempt or while write runs, cleared at write end, by a control write with the bit at 0 and no start, or by reset
module nv_byte_store_ctrl
	import nv_store_pkg::*;
#(
	parameter int write_len   = write_cycles,
	parameter int powerup_len = powerup_cycles
)(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        external_access,
	input  wire logic        code_protect,
	input  wire logic        low_power_mode,
	output logic             force_high_power,
	output logic             store_done_irq
);
	// Whole module state
	typedef struct packed {
		logic                  aw_held;
		logic [7:0]            aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic [7:0]            addr_high;
		logic [7:0]            addr_low;
		logic [7:0]            data_byte;
		logic [7:0]            control;
		logic [7:0]            priority_reg;
		logic [7:0]            flags;
		logic [7:0]            enables;
		unlock_step_t          step;
		logic                  busy;
		logic [15:0]           wcount;
		logic [15:0]           pcount;
		logic                  pwrt_done;
		logic                  read_pend;
		logic                  mem_wr;
		logic                  hi_power;
		logic                  irq;
		logic [1:0]            ext_sync;
		logic [1:0]            cp_sync;
		logic [1:0]            lp_sync;
	} state_t;

	state_t st;
	state_t next_st;
	logic [7:0] mem_rdata;             // Array read data
	mem_req_t   mem_req;               // Array request

	// Pin inputs after two flops
	logic ext_s;
	logic cp_s;
	logic lp_s;
	assign ext_s = st.ext_sync[1];
	assign cp_s  = st.cp_sync[1];
	assign lp_s  = st.lp_sync[1];

	logic blocked;
	assign blocked = ext_s && cp_s;

	assign mem_req.wr    = st.mem_wr;
	assign mem_req.addr  = {st.addr_high[1:0], st.addr_low};
	assign mem_req.wdata = st.data_byte;
	nv_byte_array u_array (
		.clk   (clk),
		.req   (mem_req),
		.rdata (mem_rdata)
	);

	// Next-state logic
	always_comb begin
		logic       wr_go;
		logic [7:0] wb;
		logic       ctl_wr;
		logic       done_set;
		wr_go   = 1'b0;
		wb      = byte_zero;
		ctl_wr  = 1'b0;
		done_set = 1'b0;
		next_st = st;
		next_st.mem_wr   = 1'b0;
		next_st.ext_sync = {st.ext_sync[0], external_access};
		next_st.cp_sync  = {st.cp_sync[0], code_protect};
		next_st.lp_sync  = {st.lp_sync[0], low_power_mode};

		if (!st.pwrt_done) begin
			if (st.pcount == 16'(powerup_len - 1)) begin
				next_st.pwrt_done = 1'b1;
			end else begin
				next_st.pcount = st.pcount + 16'h0001;
			end
		end

		if (st.read_pend) begin
			next_st.read_pend = 1'b0;
			next_st.data_byte = mem_rdata;
			next_st.control[ctl_read_bit] = 1'b0;
		end

		if (st.busy) begin
			if (st.wcount == 16'(write_len - 1)) begin
				next_st.busy = 1'b0;
				next_st.mem_wr = 1'b1;
				next_st.control[ctl_start_bit] = 1'b0;
				next_st.control[ctl_abort_bit] = 1'b0;
				next_st.flags[done_bit] = 1'b1;
				done_set = 1'b1;
			end else begin
				next_st.wcount = st.wcount + 16'h0001;
			end
		end

		// Address and data capture
		if (!st.aw_held && s_axi_awvalid) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (!st.w_held && s_axi_wvalid) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end

		// Register write
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = resp_okay;
			wb = st.w_data[7:0];
			if (blocked) begin
				next_st.bresp = resp_slverr;
			end else if (st.w_strb[0]) begin
				if (st.aw_addr != unlock_port_off) begin
					next_st.step = unlock_idle;
				end
				case (st.aw_addr)
					addr_high_off: if (!st.busy) next_st.addr_high = wb;
					addr_low_off:  if (!st.busy) next_st.addr_low = wb;
					data_byte_off: if (!st.busy) next_st.data_byte = wb;
					unlock_port_off: begin
						if (st.step == unlock_idle && wb == key_first) begin
							next_st.step = unlock_got_first;
						end else if (st.step == unlock_got_first && wb == key_second) begin
							next_st.step = unlock_armed;
						end else begin
							next_st.step = unlock_idle;
						end
					end
					control_off: ctl_wr = !st.busy;
					priority_off: next_st.priority_reg[done_bit] = wb[done_bit];
					flags_off: next_st.flags[done_bit] = (wb[done_bit] & st.flags[done_bit]) | done_set;
					enables_off: next_st.enables[done_bit] = wb[done_bit];
					default: next_st.bresp = resp_slverr;
				endcase
			end
		end

		// Control register write
		if (ctl_wr) begin
			next_st.control[ctl_pgd_bit]    = wb[ctl_pgd_bit];
			next_st.control[ctl_config_space_select_bit]   = wb[ctl_config_space_select_bit];
			next_st.control[ctl_free_bit]   = wb[ctl_free_bit];
			next_st.control[ctl_unlock_bit] = wb[ctl_unlock_bit];
			next_st.control[ctl_abort_bit]  = wb[ctl_abort_bit] & st.control[ctl_abort_bit];
			if (wb[ctl_read_bit] && !wb[ctl_pgd_bit] && !wb[ctl_config_space_select_bit] && !wb[ctl_start_bit]) begin
				next_st.control[ctl_read_bit] = 1'b1;
				next_st.read_pend = 1'b1;
			end
			if (wb[ctl_start_bit]) begin
				wr_go = st.control[ctl_unlock_bit] && wb[ctl_unlock_bit]
					&& st.step == unlock_armed && st.pwrt_done;
				if (wr_go) begin
					next_st.control[ctl_start_bit] = 1'b1;
					next_st.control[ctl_abort_bit] = 1'b1;
					next_st.busy   = 1'b1;
					next_st.wcount = 16'h0000;
					if (lp_s) next_st.hi_power = 1'b1;
				end else begin
					next_st.control[ctl_abort_bit] = 1'b1;
				end
			end
			next_st.step = unlock_idle;
		end
		if (!lp_s) next_st.hi_power = 1'b0;

		// Write response handshake
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// Register read
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = resp_okay;
			next_st.rdata  = 32'h0000_0000;
			if (blocked) begin
				next_st.rresp = resp_slverr;
			end else begin
				case (s_axi_araddr)
					addr_high_off:   next_st.rdata[7:0] = st.addr_high;
					addr_low_off:    next_st.rdata[7:0] = st.addr_low;
					data_byte_off:   next_st.rdata[7:0] = st.data_byte;
					unlock_port_off: next_st.rdata[7:0] = byte_zero;
					control_off:     next_st.rdata[7:0] = st.control;
					priority_off:    next_st.rdata[7:0] = st.priority_reg;
					flags_off:       next_st.rdata[7:0] = st.flags;
					enables_off:     next_st.rdata[7:0] = st.enables;
					status_off:      next_st.rdata[7:0] = {5'h00, st.pwrt_done, st.hi_power, st.busy};
					default:         next_st.rresp = resp_slverr;
				endcase
			end
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		next_st.irq = next_st.flags[done_bit] & next_st.enables[done_bit];
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.control <= ctl_reset;
			st.step    <= unlock_idle;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready    = !st.aw_held;
	assign s_axi_wready     = !st.w_held;
	assign s_axi_bvalid     = st.bvalid;
	assign s_axi_bresp      = st.bresp;
	assign s_axi_arready    = !st.rvalid;
	assign s_axi_rvalid     = st.rvalid;
	assign s_axi_rdata      = st.rdata;
	assign s_axi_rresp      = st.rresp;
	assign force_high_power = st.hi_power;
	assign store_done_irq   = st.irq;

	// Helper strobes for assertions
	logic ctl_wr_seen;
	logic ctl_flags_wr;
	assign ctl_wr_seen  = st.aw_held && st.w_held && !st.bvalid && st.aw_addr == control_off;
	assign ctl_flags_wr = st.aw_held && st.w_held && !st.bvalid && st.aw_addr == flags_off;

	// Assertions
	// done at end
	a_done_on_finish: assert property (@(posedge clk) disable iff (!arst_n)
		st.busy && !next_st.busy |=> st.flags[done_bit] && !st.control[ctl_start_bit])
		else $error("done flag not set at write end");
	a_unlock_held: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(st.control[ctl_unlock_bit]) |-> $past(ctl_wr_seen))
		else $error("write enable cleared by hardware");
	a_start_needs_key: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(st.busy) |-> $past(st.step) == unlock_armed)
		else $error("write started without keys");
	a_start_needs_en: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(st.busy) |-> $past(st.control[ctl_unlock_bit]))
		else $error("write started without prior enable");
	a_frozen_busy: assert property (@(posedge clk) disable iff (!arst_n)
		st.busy && $past(st.busy) |-> $stable(st.data_byte) && $stable(st.addr_low))
		else $error("register changed during write");
	a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(st.flags[done_bit]) |-> $past(ctl_flags_wr))
		else $error("done flag cleared by hardware");
	a_pwrt_block: assert property (@(posedge clk) disable iff (!arst_n)
		!st.pwrt_done |=> !$rose(st.busy))
		else $error("write during power-up timer");
	a_read_one: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(st.read_pend) |=> !st.control[ctl_read_bit])
		else $error("read bit not cleared");
	a_protect: assert property (@(posedge clk) disable iff (!arst_n)
		s_axi_arvalid && !st.rvalid && blocked |=> st.rresp == resp_slverr)
		else $error("external read not refused");

	// Covers
	c_write_done: cover property (@(posedge clk) disable iff (!arst_n) $fell(st.busy));
	c_read_done: cover property (@(posedge clk) disable iff (!arst_n) $fell(st.read_pend));
	c_bad_start: cover property (@(posedge clk) disable iff (!arst_n) $rose(st.control[ctl_abort_bit]) && !st.busy);
endmodule : nv_byte_store_ctrl

// *** tb_top.sv ***
// Testbench for the byte store controller: register bus, unlock sequence and self-timed write
`timescale 1ns/1ps
module tb_top
	import nv_store_pkg::*;
;
	localparam int          wr_len = 40;                    // Shortened self-timed write
	localparam int          pu_len = 80;                    // Shortened power-up timer
	localparam logic [31:0] rd_v   = 32'h1 << ctl_read_bit;   // Read request bit
	localparam logic [31:0] st_v   = 32'h1 << ctl_start_bit;  // Start bit
	localparam logic [31:0] en_v   = 32'h1 << ctl_unlock_bit; // Write enable bit
	localparam logic [31:0] ab_v   = 32'h1 << ctl_abort_bit;  // Abort flag bit
	localparam logic [31:0] dn_v   = 32'h1 << done_bit;       // Done flag bit

	logic        clk, arst_n;                                 // Clock and reset
	logic [7:0]  awaddr, araddr;                              // Bus addresses
	logic        awvalid, awready, wvalid, wready;            // Write request handshakes
	logic        bvalid, bready, arvalid, arready, rvalid, rready; // Response and read handshakes
	logic [31:0] wdata, rdata;                                // Bus data
	logic [3:0]  wstrb;                                       // Byte lanes
	logic [1:0]  bresp, rresp;                                // Responses
	logic        ext_acc, prot, low_pwr, high_pwr, done_irq;  // Side signals
	int          err_count, cmp_count;                        // Tallies

	nv_byte_store_ctrl #(.write_len(wr_len), .powerup_len(pu_len)) nv_byte_store_ctrl_i (
		.clk(clk), .arst_n(arst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_access(ext_acc), .code_protect(prot), .low_power_mode(low_pwr),
		.force_high_power(high_pwr), .store_done_irq(done_irq)
	);

	// Free-running clock
	always #4 clk = ~clk;

	// Verdict and end of run
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	// Compare one value
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// A wait that ran out
	task automatic hang(input string what);
		err_count++;
		$display("Error %s expected answer seen timeout", what);
		end_of_test();
	endtask : hang

	// Bus write: address and data offered together, each released when taken
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
		bit ap;
		bit wp;
		ap = 1;
		wp = 1;
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge clk);
			if (!ap && !wp && bvalid === 1'b1) begin
				resp = bresp;
				return;
			end
			if (ap && awready === 1'b1) begin
				awvalid <= 1'b0;
				ap = 0;
			end
			if (wp && wready === 1'b1) begin
				wvalid <= 1'b0;
				wp = 0;
			end
		end
		hang("write answer");
	endtask : bus_wr

	// Bus read: address held until taken, data taken with rvalid
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		bit ap;
		ap = 1;
		araddr  <= a;
		arvalid <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge clk);
			if (!ap && rvalid === 1'b1) begin
				d = rdata;
				resp = rresp;
				return;
			end
			if (ap && arready === 1'b1) begin
				arvalid <= 1'b0;
				ap = 0;
			end
		end
		hang("read answer");
	endtask : bus_rd

	// Accepted write and read
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		bus_wr(a, d, r);
		chk("write response", r, resp_okay);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		bus_rd(a, d, r);
		chk("read response", r, resp_okay);
	endtask : rd

	// Address, data, enable, keys, start; broken puts a data write between the keys
	task automatic store(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d, input bit broken);
		wr(addr_high_off, hi);
		wr(addr_low_off, lo);
		wr(data_byte_off, d);
		wr(control_off, en_v[7:0]);
		wr(unlock_port_off, key_first);
		if (broken) wr(data_byte_off, 8'h00);
		wr(unlock_port_off, key_second);
		wr(control_off, en_v[7:0] | st_v[7:0]);
	endtask : store

	// poll start bit until the write finishes
	task automatic wait_idle();
		logic [31:0] d;
		for (int n = 0; n < 60; n++) begin
			rd(control_off, d);
			if ((d & st_v) === 32'h0) return;
		end
		hang("write completion");
	endtask : wait_idle

	// Read one location back and compare
	task automatic load(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
		logic [31:0] d;
		wr(addr_high_off, hi);
		wr(addr_low_off, lo);
		wr(control_off, en_v[7:0] | rd_v[7:0]);
		repeat (2) @(posedge clk);
		rd(data_byte_off, d);
		chk("stored byte", d, {24'h0, exp});
		rd(control_off, d);
		chk("read bit", d & rd_v, 32'h0);
	endtask : load

	// Reset values, blind port, unmapped place, power-up blocking
	task automatic t_start();
		logic [31:0] d;
		logic [1:0]  r;
		rd(control_off, d);
		chk("control at reset", d, 32'h0);
		rd(unlock_port_off, d);
		chk("unlock port", d, 32'h0);
		bus_rd(8'h24, d, r);
		chk("unmapped", r, resp_slverr);
		store(8'h00, 8'h00, 8'h5a, 0);
		rd(control_off, d);
		chk("start early", d & st_v, 32'h0);
		rd(status_off, d);
		chk("timer running", d[2], 1'b0);
		repeat (pu_len) @(posedge clk);
		rd(status_off, d);
		chk("timer done", d[2], 1'b1);
		$display("Test start done");
	endtask : t_start

	// Enable and start together, start without enable
	task automatic t_refuse();
		logic [31:0] d;
		wr(control_off, rd_v[7:0] | 8'(1 << ctl_pgd_bit));
		rd(control_off, d);
		chk("read with program space", d & rd_v, 32'h0);
		wr(control_off, 8'h00);
		// keys given, enable only in start write
		wr(unlock_port_off, key_first);
		wr(unlock_port_off, key_second);
		wr(control_off, en_v[7:0] | st_v[7:0]);
		rd(control_off, d);
		chk("start with enable", d & st_v, 32'h0);
		chk("abort flag", d & ab_v, ab_v);
		wr(control_off, 8'h00);
		wr(unlock_port_off, key_first);
		wr(unlock_port_off, key_second);
		wr(control_off, st_v[7:0]);
		rd(control_off, d);
		chk("start no enable", d & st_v, 32'h0);
		$display("Test refuse done");
	endtask : t_refuse

	// Full write in low power with interrupt enabled, edits while busy
	task automatic t_write();
		logic [31:0] d;
		wr(enables_off, dn_v[7:0]);
		low_pwr <= 1'b1;
		repeat (4) @(posedge clk);
		store(8'hfd, 8'h23, 8'hc3, 0);
		rd(control_off, d);
		chk("start running", d & st_v, st_v);
		chk("high power", high_pwr, 1'b1);
		wr(data_byte_off, 8'h11);
		wr(control_off, 8'h00);
		wait_idle();
		rd(control_off, d);
		chk("enable kept", d & en_v, en_v);
		chk("abort cleared", d & ab_v, 32'h0);
		rd(flags_off, d);
		chk("done flag", d & dn_v, dn_v);
		chk("done irq", done_irq, 1'b1);
		low_pwr <= 1'b0;
		load(8'h01, 8'h23, 8'hc3);
		chk("high power off", high_pwr, 1'b0);
		rd(flags_off, d);
		chk("flag holds", d & dn_v, dn_v);
		wr(flags_off, 8'h00);
		rd(flags_off, d);
		chk("flag cleared", d & dn_v, 32'h0);
		chk("irq cleared", done_irq, 1'b0);
		$display("Test write done");
	endtask : t_write

	// Broken key sequence leaves memory alone
	task automatic t_broken();
		logic [31:0] d;
		store(8'h01, 8'h23, 8'h77, 1);
		rd(control_off, d);
		chk("broken start", d & st_v, 32'h0);
		load(8'h01, 8'h23, 8'hc3);
		$display("Test broken done");
	endtask : t_broken

	// Code protect: internal works, external refused
	task automatic t_protect();
		logic [31:0] d;
		logic [1:0]  r;
		prot <= 1'b1;
		repeat (4) @(posedge clk);
		store(8'h02, 8'h00, 8'h9e, 0);
		wait_idle();
		load(8'h02, 8'h00, 8'h9e);
		store(8'h02, 8'h00, 8'h9e, 0);
		wait_idle();
		load(8'h02, 8'h00, 8'h9e);
		ext_acc <= 1'b1;
		repeat (4) @(posedge clk);
		bus_rd(data_byte_off, d, r);
		chk("outside read", r, resp_slverr);
		bus_wr(data_byte_off, 8'h33, r);
		chk("outside write", r, resp_slverr);
		ext_acc <= 1'b0;
		repeat (4) @(posedge clk);
		rd(data_byte_off, d);
		chk("data untouched", d, 32'h9e);
		prot <= 1'b0;
		$display("Test protect done");
	endtask : t_protect

	// Main sequence
	initial begin
		clk       = 1'b0;
		arst_n    = 1'b0;
		awaddr    = 8'h00;
		araddr    = 8'h00;
		awvalid   = 1'b0;
		wvalid    = 1'b0;
		arvalid   = 1'b0;
		wdata     = 32'h0;
		wstrb     = 4'h1;
		bready    = 1'b1;
		rready    = 1'b1;
		ext_acc   = 1'b0;
		prot      = 1'b0;
		low_pwr   = 1'b0;
		err_count = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_start();
		t_refuse();
		t_write();
		t_broken();
		t_protect();
		end_of_test();
	end

endmodule : tb_top
